//--- design/sms_consts.svh
// constants for the serial peripheral register block
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define SMS_IDX_W 6
`define SMS_IDX_DATA 6'h21
`define SMS_IDX_CTRL 6'h22
`define SMS_IDX_STAT 6'h23

// ----------------------------------------------------------------
// serial_control fields
// ----------------------------------------------------------------
`define SMS_CTRL_IRQ_EN 7
`define SMS_CTRL_PORT_EN 6
`define SMS_CTRL_DIV_HIGH 5
`define SMS_CTRL_MASTER 4
`define SMS_CTRL_CLOCK_IDLE_POLARITY 3
`define SMS_CTRL_CLOCK_CAPTURE_PHASE 2
`define SMS_CTRL_RATE1 1
`define SMS_CTRL_RATE0 0
`define SMS_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// serial_control_status fields
// ----------------------------------------------------------------
`define SMS_STAT_DONE 7
`define SMS_STAT_CLASH 6
`define SMS_STAT_OVR 5
`define SMS_STAT_MODE_FAULT_FLAG 4
`define SMS_STAT_RSVD 3
`define SMS_STAT_SOD 2
`define SMS_STAT_SSM 1
`define SMS_STAT_SSI 0
`define SMS_STAT_RESET 8'h00

// ----------------------------------------------------------------
// pin bit positions inside the input pin vector
// ----------------------------------------------------------------
`define SMS_PIN_SCK 3
`define SMS_PIN_MOSI 2
`define SMS_PIN_MISO 1
`define SMS_PIN_SS 0

// ----------------------------------------------------------------
// master clock: half sck periods in mclk cycles, and index of the last of a byte's sck edges
// ----------------------------------------------------------------
`define SMS_HALF_DIV4 7'h02
`define SMS_HALF_DIV8 7'h04
`define SMS_HALF_DIV16 7'h08
`define SMS_HALF_DIV32 7'h10
`define SMS_HALF_DIV64 7'h20
`define SMS_HALF_DIV128 7'h40
`define SMS_EDGE_LAST 4'hf

`endif

//--- design/sms_pkg.sv
// types for the serial peripheral register block
package sms_pkg;

   // ----------------------------------------------------------------
   // transfer engine states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SMS_IDLE,
      SMS_SHIFT,
      SMS_FINISH
   } sms_state_t;

   // ----------------------------------------------------------------
   // pin groups
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } sms_pin_in_t;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
   } sms_pin_out_t;

endpackage : sms_pkg

//--- design/sms_spi_regs.sv
// serial peripheral (master or slave) with its three registers on ahb-lite
//
// Contract
// - irq_enable gates done, mode fault and overrun flags onto the interrupt.
// - port_enable connects the serial pins; reset clears it.
// - master_select drives sck out and swaps mosi/miso roles.
// - clock_idle_polarity sets sck idle level in both modes; here it sets only the master's sck, slave mode ignores it.
// - clock_capture_phase picks first or second sck transition for first capture.
// - master sck rate is mclk divided by 4..128 per the three rate bits.
// - rate bits have no effect in slave mode; sck comes from outside.
// - done flag sets at byte end; clears by status read then data access.
// - data writes are ignored while done is set until status is read.
// - writing data during a transfer sets the clash flag; never interrupts.
// - overrun sets if a byte completes while done is set; status read clears.
// - low select in master mode sets mode fault, clears port_enable and master.
// - status bit 3 reads zero; software writes it zero.
// - output_disable stops driving mosi (master) or miso (slave).
// - select_soft_manage ignores the select pin and uses select_soft_level.
// - select_soft_level 0 selects, 1 deselects.
// - data write loads the shift register; in master mode it starts a byte.
// - byte end copies shift register into receive buffer; reads return buffer.
// - reset clears control upper bits and all status bits.
// - colliding write is discarded; the running transfer is undisturbed.
// - after overrun the buffer keeps the first byte; later bytes are lost.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "sms_consts.svh"

module sms_spi_regs (
   input wire logic mclk,                        // 250 mhz system clock
   input wire logic reset_n,                     // asynchronous reset, active low
   input wire logic hsel,                        // ahb slave select
   input wire logic [31:0] haddr,                // ahb address
   input wire logic [1:0] htrans,                // ahb transfer type
   input wire logic hwrite,                      // ahb write
   input wire logic [2:0] hsize,                 // ahb size (word only)
   input wire logic [31:0] hwdata,               // ahb write data
   input wire logic hready,                      // ahb bus ready
   output logic hreadyout,                       // ahb slave ready
   output logic [31:0] hrdata,                   // ahb read data
   output logic hresp,                           // ahb response, always okay
   input wire sms_pkg::sms_pin_in_t pin_level,   // raw pin levels
   output sms_pkg::sms_pin_out_t pin_drive,      // pin drive values and enables
   output logic irq                              // interrupt, active high
);
   import sms_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [3:0] sy1_q, sy2_q, sy3_q, lvl_q, lvl_d, agree;
   logic [7:0] ctrl_q;
   logic done_q, clash_q, ovr_q, mode_fault_flag_q, sod_q, ssm_q, ssi_q;
   logic seen_q, mode_fault_flag_seen_q;
   logic wp_q;
   logic [`SMS_IDX_W-1:0] wp_idx_q, idx;
   logic ap, hit, rd_stat, rd_data, wr_data, wr_ctrl, wr_stat, data_acc;
   sms_state_t state_q;
   logic [3:0] edge_q;
   logic [6:0] div_q, half;
   logic sck_q, samp_q;
   logic [7:0] sh_q, rx_q, rx_new, stat_val;
   logic master, pe, clock_capture_phase, ss_int, sel_slave, mode_fault_flag_ev, busy, tick, sck_edge;
   logic in_bit, edge_ev, sample_now, shift_now, complete, abort, start, wr_ok, clash_ev;

   // ----------------------------------------------------------------
   // pin synchronisers: a change counts once stages two and three agree
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sy1_q <= 4'h1;
         sy2_q <= 4'h1;
         sy3_q <= 4'h1;
         lvl_q <= 4'h1;
      end else begin
         sy1_q <= pin_level;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         lvl_q <= lvl_d;
      end
   end

   assign agree = ~(sy2_q ^ sy3_q);
   assign lvl_d = (agree & sy3_q) | (~agree & lvl_q);
   assign sck_edge = lvl_d[`SMS_PIN_SCK] ^ lvl_q[`SMS_PIN_SCK];

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   assign master = ctrl_q[`SMS_CTRL_MASTER];
   assign pe = ctrl_q[`SMS_CTRL_PORT_EN];
   assign clock_capture_phase = ctrl_q[`SMS_CTRL_CLOCK_CAPTURE_PHASE];
   assign ss_int = ssm_q ? ssi_q : lvl_q[`SMS_PIN_SS];
   assign sel_slave = pe && !master && !ss_int;
   assign mode_fault_flag_ev = master && !ss_int;

   always_comb begin
      case ({ctrl_q[`SMS_CTRL_DIV_HIGH], ctrl_q[`SMS_CTRL_RATE1], ctrl_q[`SMS_CTRL_RATE0]})
         3'h4: half = `SMS_HALF_DIV4;
         3'h0: half = `SMS_HALF_DIV8;
         3'h1: half = `SMS_HALF_DIV16;
         3'h6: half = `SMS_HALF_DIV32;
         3'h2: half = `SMS_HALF_DIV64;
         3'h3: half = `SMS_HALF_DIV128;
         default: half = `SMS_HALF_DIV8;
      endcase
   end

   // ----------------------------------------------------------------
   // ahb-lite slave: zero wait states, reads act in the address phase
   // ----------------------------------------------------------------
   assign ap = hsel && hready && htrans[1];
   assign idx = haddr[`SMS_IDX_W+1:2];
   assign hit = (haddr[31:`SMS_IDX_W+2] == 24'h000000) && (haddr[1:0] == 2'h0);
   assign rd_stat = ap && !hwrite && hit && (idx == `SMS_IDX_STAT);
   assign rd_data = ap && !hwrite && hit && (idx == `SMS_IDX_DATA);
   assign wr_data = wp_q && (wp_idx_q == `SMS_IDX_DATA);
   assign wr_ctrl = wp_q && (wp_idx_q == `SMS_IDX_CTRL);
   assign wr_stat = wp_q && (wp_idx_q == `SMS_IDX_STAT);
   assign data_acc = rd_data || wr_data;
   assign stat_val = {done_q, clash_q, ovr_q, mode_fault_flag_q, 1'b0, sod_q, ssm_q, ssi_q};

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wp_q <= 1'b0;
         wp_idx_q <= '0;
      end else begin
         wp_q <= ap && hwrite && hit;
         wp_idx_q <= idx;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (ap && !hwrite) begin
            if (rd_stat) begin
               hrdata <= {24'h000000, stat_val};
            end else if (rd_data) begin
               hrdata <= {24'h000000, rx_q};
            end else if (hit && (idx == `SMS_IDX_CTRL)) begin
               hrdata <= {24'h000000, ctrl_q};
            end else begin
               hrdata <= 32'h00000000;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= `SMS_CTRL_RESET;
      end else if (mode_fault_flag_ev) begin
         ctrl_q[`SMS_CTRL_PORT_EN] <= 1'b0;
         ctrl_q[`SMS_CTRL_MASTER] <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_q <= hwdata[7:0];
         if (mode_fault_flag_q && !mode_fault_flag_seen_q) begin
            ctrl_q[`SMS_CTRL_PORT_EN] <= 1'b0;
            ctrl_q[`SMS_CTRL_MASTER] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // status register: software bits and hardware flags (set wins)
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sod_q <= 1'b0;
         ssm_q <= 1'b0;
         ssi_q <= 1'b0;
      end else if (wr_stat) begin
         sod_q <= hwdata[`SMS_STAT_SOD];
         ssm_q <= hwdata[`SMS_STAT_SSM];
         ssi_q <= hwdata[`SMS_STAT_SSI];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         seen_q <= 1'b0;
         mode_fault_flag_seen_q <= 1'b0;
      end else begin
         if (rd_stat) begin
            seen_q <= 1'b1;
         end else if (data_acc) begin
            seen_q <= 1'b0;
         end
         if (rd_stat && mode_fault_flag_q) begin
            mode_fault_flag_seen_q <= 1'b1;
         end else if (wr_ctrl) begin
            mode_fault_flag_seen_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         done_q <= 1'b0;
         clash_q <= 1'b0;
         ovr_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
      end else begin
         if (complete) begin
            done_q <= 1'b1;
         end else if (data_acc && seen_q) begin
            done_q <= 1'b0;
         end
         if (clash_ev) begin
            clash_q <= 1'b1;
         end else if (data_acc && seen_q) begin
            clash_q <= 1'b0;
         end
         if (complete && done_q) begin
            ovr_q <= 1'b1;
         end else if (rd_stat) begin
            ovr_q <= 1'b0;
         end
         if (mode_fault_flag_ev) begin
            mode_fault_flag_q <= 1'b1;
         end else if (wr_ctrl && mode_fault_flag_seen_q) begin
            mode_fault_flag_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // transfer engine
   // ----------------------------------------------------------------
   assign busy = (state_q != SMS_IDLE);
   assign tick = (div_q == (half - 7'h01));
   assign in_bit = master ? lvl_q[`SMS_PIN_MISO] : lvl_q[`SMS_PIN_MOSI];
   assign edge_ev = master ? ((state_q == SMS_SHIFT) && tick)
                           : (sel_slave && sck_edge && (state_q != SMS_FINISH));
   assign sample_now = edge_ev && (edge_q[0] == clock_capture_phase);
   assign shift_now = edge_ev && (edge_q[0] != clock_capture_phase) && (edge_q != 4'h0);
   assign complete = (state_q == SMS_FINISH) && (!master || tick);
   assign abort = master ? (mode_fault_flag_ev || !pe) : ((state_q == SMS_SHIFT) && !sel_slave);
   assign wr_ok = wr_data && !busy && !(done_q && !seen_q);
   assign clash_ev = wr_data && busy;
   assign start = wr_ok && master && pe;
   assign rx_new = clock_capture_phase ? {sh_q[6:0], samp_q} : sh_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= SMS_IDLE;
         edge_q <= 4'h0;
      end else if (abort) begin
         state_q <= SMS_IDLE;
         edge_q <= 4'h0;
      end else begin
         case (state_q)
            SMS_IDLE: begin
               if (start) begin
                  state_q <= SMS_SHIFT;
                  edge_q <= 4'h0;
               end else if (edge_ev) begin
                  state_q <= SMS_SHIFT;
                  edge_q <= 4'h1;
               end
            end
            SMS_SHIFT: begin
               if (edge_ev) begin
                  edge_q <= edge_q + 4'h1;
                  if (edge_q == `SMS_EDGE_LAST) begin
                     state_q <= SMS_FINISH;
                  end
               end
            end
            SMS_FINISH: begin
               if (complete) begin
                  state_q <= SMS_IDLE;
               end
            end
            default: begin
               state_q <= SMS_IDLE;
            end
         endcase
      end
   end

   // master half-period counter; idle in slave mode
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= 7'h00;
      end else if (master && busy && !tick) begin
         div_q <= div_q + 7'h01;
      end else begin
         div_q <= 7'h00;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sck_q <= 1'b0;
      end else if (!master || !busy) begin
         sck_q <= ctrl_q[`SMS_CTRL_CLOCK_IDLE_POLARITY];
      end else if (edge_ev) begin
         sck_q <= ~sck_q;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sh_q <= 8'h00;
         samp_q <= 1'b0;
      end else begin
         if (sample_now) begin
            samp_q <= in_bit;
         end
         if (wr_ok) begin
            sh_q <= hwdata[7:0];
         end else if (shift_now) begin
            sh_q <= {sh_q[6:0], samp_q};
         end else if (complete) begin
            sh_q <= rx_new;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_q <= 8'h00;
      end else if (complete && !done_q) begin
         rx_q <= rx_new;
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= ctrl_q[`SMS_CTRL_IRQ_EN] && (done_q || mode_fault_flag_q || ovr_q);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pin_drive <= '0;
      end else begin
         pin_drive.sck_o <= sck_q;
         pin_drive.sck_oe <= pe && master;
         pin_drive.mosi_o <= sh_q[7];
         pin_drive.mosi_oe <= pe && master && !sod_q;
         pin_drive.miso_o <= sh_q[7];
         pin_drive.miso_oe <= pe && !master && !sod_q && !ss_int;
      end
   end

endmodule : sms_spi_regs

//--- test/sms_spi_regs_props.sv
// checker for the serial peripheral register block
`timescale 1ns/1ps
module sms_spi_regs_props import sms_pkg::*; (
   input wire logic mclk,                      // clock
   input wire logic reset_n,                   // reset
   input wire logic hsel,                      // select
   input wire logic [31:0] haddr,              // address
   input wire logic [1:0] htrans,              // type
   input wire logic hwrite,                    // write
   input wire logic hready,                    // ready
   input wire logic hreadyout,                 // ready out
   input wire logic [31:0] hrdata,             // read data
   input wire logic hresp,                     // response
   input wire sms_pkg::sms_pin_out_t pin_drive, // pins
   input wire logic irq                        // interrupt
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------------------------------
   // read address phase taken
   // ----------------------------------------------------------------
   sequence rd_take;
      hsel && hready && htrans[1] && !hwrite;
   endsequence

   a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus answer not okay or not ready");
   a_rdata_narrow: assert property (hrdata[31:8] == 24'h0)
      else $error("upper read data bits set");
   a_rsvd_zero: assert property (rd_take ##0 haddr == 32'h8c |=> hrdata[3] == 1'b0)
      else $error("reserved status bit read as one");
   a_unmapped_zero: assert property (rd_take ##0 !(haddr inside {32'h84, 32'h88, 32'h8c}) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   a_sck_half_min: assert property (pin_drive.sck_oe && $past(pin_drive.sck_oe) && $changed(pin_drive.sck_o)
      |=> !pin_drive.sck_oe || $stable(pin_drive.sck_o))
      else $error("serial clock half period below two cycles");
   a_sck_no_miso: assert property (pin_drive.sck_oe |-> !pin_drive.miso_oe)
      else $error("clock driven while slave output driven");
   a_out_single: assert property (!(pin_drive.mosi_oe && pin_drive.miso_oe))
      else $error("both data outputs driven");
   a_reset_quiet: assert property (!$past(reset_n) |-> pin_drive == 6'h00 && irq == 1'b0)
      else $error("pins or interrupt active after reset");
endmodule : sms_spi_regs_props

bind sms_spi_regs sms_spi_regs_props u_props (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .pin_drive(pin_drive), .irq(irq));

//--- test/sms_spi_peer.sv
// spi slave partner model, clock phase 0 only, one byte per selection
`timescale 1ns/1ps
module sms_spi_peer (
   input wire logic mclk,          // sample clock
   input wire logic sel_n,         // select, active low
   input wire logic clock_idle_polarity,          // idle level
   input wire logic sck,           // serial clock
   input wire logic mosi,          // data in
   input wire logic [7:0] tx_byte, // byte to send
   output logic miso,              // data out
   output logic [7:0] rx_byte,     // last byte received
   output int nbytes               // bits received
);
   logic sck_q = 1'b0;
   logic [7:0] tx_q = 8'h00;
   logic [7:0] in_q = 8'h00;
   // released line shows the inverse level so a stale bit cannot pass
   assign miso = sel_n ? ~tx_q[7] : tx_q[7];
   initial nbytes = 0;
   always @(posedge mclk) begin
      sck_q <= sck;
      if (sel_n) begin
         tx_q <= tx_byte;
         in_q <= 8'h00;
      end else if (sck != sck_q && sck_q == clock_idle_polarity) begin
         in_q <= {in_q[6:0], mosi};
         rx_byte <= {in_q[6:0], mosi};
         nbytes <= nbytes + 1;
      end else if (sck != sck_q) begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end
endmodule : sms_spi_peer

//--- test/sms_spi_regs_tb_top.sv
// testbench for the serial peripheral register block
`timescale 1ns/1ps
`include "sms_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %0t mismatch %h vs %h", $time, (g), (e)); end end
module sms_spi_regs_tb_top;
   import sms_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   logic irq;
   logic ss_pin = 1'b1;
   logic ext_sck = 1'b0;
   logic ext_mosi = 1'b1;
   logic peer_sel_n = 1'b1;
   logic [7:0] peer_tx = 8'h00;
   logic peer_miso;
   logic [7:0] peer_rx;
   int peer_n;
   sms_pin_in_t pin_level;
   sms_pin_out_t pin_drive;
   int miscompares = 0;
   int samples_checked = 0;
   int toggles = 0;
   logic sck_last = 1'b0;
   logic [7:0] rd;
   logic [7:0] rate_code [6] = '{8'h20, 8'h00, 8'h01, 8'h22, 8'h02, 8'h03};
   int rate_div [6] = '{4, 8, 16, 32, 64, 128};
   int n;
   int t0;

   always #2 mclk = ~mclk;
   // undriven clock and mosi lines follow the bench acting as external master
   assign pin_level = {pin_drive.sck_oe ? pin_drive.sck_o : ext_sck,
      pin_drive.mosi_oe ? pin_drive.mosi_o : ext_mosi,
      pin_drive.miso_oe ? pin_drive.miso_o : peer_miso, ss_pin};
   always @(posedge mclk) begin
      sck_last <= pin_drive.sck_o;
      if (pin_drive.sck_o !== sck_last) toggles <= toggles + 1;
   end

   sms_spi_regs dut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .pin_level(pin_level), .pin_drive(pin_drive), .irq(irq));
   sms_spi_peer peer (.mclk(mclk), .sel_n(peer_sel_n), .clock_idle_polarity(1'b0), .sck(pin_level.sck),
      .mosi(pin_level.mosi), .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx), .nbytes(peer_n));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic complete_run;
      $display("checked %0d, mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   task automatic guard(input int k, input int lim);
      if (k >= lim) begin
         miscompares++;
         $display("[ERR] %0t wait ran out", $time);
         complete_run();
      end
   endtask : guard

   task automatic wait_ready;
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 100);
      guard(k, 100);
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rv);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, idx, 2'h0};
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_ready();
      rv = hrdata[7:0];
   endtask : bus

   task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00, rd);
      `CHK(rd, exp)
   endtask : rdchk

   task automatic tick(input int c);
      repeat (c) @(posedge mclk);
   endtask : tick

   // one byte as external master, clock phase 0, idle low, msb first
   task automatic ext_byte(input logic [7:0] b);
      for (int j = 0; j < 8; j++) begin
         ext_mosi <= b[7 - j];
         tick(8);
         ext_sck <= 1'b1;
         tick(8);
         ext_sck <= 1'b0;
      end
      tick(8);
   endtask : ext_byte

   task automatic sck_gap(output int cyc);
      logic s;
      s = pin_drive.sck_o;
      cyc = 0;
      do begin
         @(posedge mclk);
         cyc++;
      end while (pin_drive.sck_o === s && cyc < 2000);
      guard(cyc, 2000);
   endtask : sck_gap

   task automatic wait_done;
      int k;
      k = 0;
      rd = 8'h00;
      while (rd[7] !== 1'b1 && k < 1000) begin
         bus(1'b0, `SMS_IDX_STAT, 8'h00, rd);
         k++;
      end
      guard(k, 1000);
   endtask : wait_done

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      rdchk(`SMS_IDX_CTRL, 8'h00);
      rdchk(`SMS_IDX_STAT, 8'h00);
      rdchk(6'h24, 8'h00);
      $display("test reset values done");
      bus(1'b1, `SMS_IDX_STAT, 8'h03, rd);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, `SMS_IDX_CTRL, 8'h50 | rate_code[i], rd);
         bus(1'b1, `SMS_IDX_DATA, 8'h00, rd);
         sck_gap(n);
         sck_gap(n);
         `CHK(n, rate_div[i] / 2)
         wait_done();
      end
      $display("test clock rates done");
      peer_tx <= 8'h3c;
      bus(1'b1, `SMS_IDX_CTRL, 8'h51, rd);
      bus(1'b0, `SMS_IDX_DATA, 8'h00, rd);
      peer_sel_n <= 1'b0;
      t0 = toggles;
      bus(1'b1, `SMS_IDX_DATA, 8'ha5, rd);
      bus(1'b1, `SMS_IDX_DATA, 8'h5a, rd);
      wait_done();
      `CHK(rd[6], 1'b1)
      `CHK(irq, 1'b0)
      rdchk(`SMS_IDX_DATA, 8'h3c);
      `CHK(peer_rx, 8'ha5)
      `CHK(toggles - t0, 16)
      `CHK(pin_drive.sck_o, 1'b0)
      rdchk(`SMS_IDX_STAT, 8'h03);
      peer_sel_n <= 1'b1;
      $display("test exchange and collision done");
      peer_tx <= 8'hc3;
      bus(1'b1, `SMS_IDX_CTRL, 8'hd1, rd);
      peer_sel_n <= 1'b0;
      bus(1'b1, `SMS_IDX_DATA, 8'h96, rd);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      guard(n, 2000);
      t0 = peer_n;
      bus(1'b1, `SMS_IDX_DATA, 8'h11, rd);
      tick(300);
      `CHK(peer_n, t0)
      rdchk(`SMS_IDX_STAT, 8'h83);
      rdchk(`SMS_IDX_DATA, 8'hc3);
      tick(2);
      `CHK(irq, 1'b0)
      `CHK(peer_rx, 8'h96)
      peer_sel_n <= 1'b1;
      $display("test ignored write and interrupt done");
      bus(1'b1, `SMS_IDX_STAT, 8'h02, rd);
      tick(4);
      `CHK(irq, 1'b1)
      rdchk(`SMS_IDX_STAT, 8'h12);
      rdchk(`SMS_IDX_CTRL, 8'h81);
      bus(1'b1, `SMS_IDX_STAT, 8'h03, rd);
      bus(1'b1, `SMS_IDX_CTRL, 8'h00, rd);
      rdchk(`SMS_IDX_STAT, 8'h03);
      $display("test mode fault done");
      bus(1'b1, `SMS_IDX_CTRL, 8'h58, rd);
      bus(1'b1, `SMS_IDX_STAT, 8'h07, rd);
      tick(2);
      `CHK(pin_drive.sck_o, 1'b1)
      `CHK(pin_drive.sck_oe, 1'b1)
      `CHK(pin_drive.mosi_oe, 1'b0)
      bus(1'b1, `SMS_IDX_STAT, 8'h03, rd);
      tick(2);
      `CHK(pin_drive.mosi_oe, 1'b1)
      bus(1'b1, `SMS_IDX_CTRL, 8'h18, rd);
      tick(2);
      `CHK({pin_drive.sck_oe, pin_drive.mosi_oe}, 2'b00)
      bus(1'b1, `SMS_IDX_CTRL, 8'h43, rd);
      bus(1'b1, `SMS_IDX_STAT, 8'h02, rd);
      tick(2);
      `CHK({pin_drive.sck_oe, pin_drive.miso_oe}, 2'b01)
      bus(1'b1, `SMS_IDX_STAT, 8'h06, rd);
      tick(2);
      `CHK(pin_drive.miso_oe, 1'b0)
      $display("test pin control done");
      ext_byte(8'h69);
      ext_byte(8'h3e);
      rdchk(`SMS_IDX_STAT, 8'ha6);
      rdchk(`SMS_IDX_STAT, 8'h86);
      rdchk(`SMS_IDX_DATA, 8'h69);
      bus(1'b1, `SMS_IDX_STAT, 8'h00, rd);
      ss_pin <= 1'b0;
      tick(8);
      `CHK(pin_drive.miso_oe, 1'b1)
      $display("test slave receive and overrun done");
      complete_run();
   end
endmodule : sms_spi_regs_tb_top
